// file: uemr_consts.svh
// Constants for the endpoint mode responder: mode codes, register bit
// positions, reset values and timing figures.
// Assumes inclusion by bare name from the responder's design files.
`ifndef UEMR_CONSTS_SVH
`define UEMR_CONSTS_SVH

// Four-bit endpoint mode codes.
`define UEMR_MODE_DISABLE 4'h0
`define UEMR_MODE_NAK_IO 4'h1
`define UEMR_MODE_STATUS_OUT 4'h2
`define UEMR_MODE_STALL_IO 4'h3
`define UEMR_MODE_IGNORE_IO 4'h4
`define UEMR_MODE_ISO_OUT 4'h5
`define UEMR_MODE_STATUS_IN 4'h6
`define UEMR_MODE_ISO_IN 4'h7
`define UEMR_MODE_NAK_OUT 4'h8
`define UEMR_MODE_ACK_OUT 4'h9
`define UEMR_MODE_NAK_OUT_SIN 4'hA
`define UEMR_MODE_ACK_OUT_SIN 4'hB
`define UEMR_MODE_NAK_IN 4'hC
`define UEMR_MODE_ACK_IN 4'hD
`define UEMR_MODE_NAK_IN_SOUT 4'hE
`define UEMR_MODE_ACK_IN_SOUT 4'hF

// Mode register layout: mode in bits 3..0.
`define UEMR_MODE_ACK_BIT 4
`define UEMR_MODE_OUT_BIT 5
`define UEMR_MODE_IN_BIT 6
`define UEMR_MODE_SETUP_BIT 7
// Count register layout: byte count in bits 3..0.
`define UEMR_CNT_DVAL_BIT 6
`define UEMR_CNT_TOG_BIT 7

// Reset values.
`define UEMR_MODE_RESET 8'h00
`define UEMR_CNT_RESET 8'h00

// Data packet CRC length in bytes.
`define UEMR_CRC_BYTES 2
// Clock rate and write lockout time.
`define UEMR_CLK_MHZ 25
`define UEMR_LOCK_TIME_NS 1000

`endif

// file: uemr_fifo.sv
// Receive buffer FIFO between the data packet input and firmware.
// Assumes one clock; both sides use valid/ready handshakes.
`timescale 1ns/1ps
module uemr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] level_q;
  logic push;
  logic pop;

  // Full and empty come straight from the fill level.
  assign in_ready = (level_q != (AW+1)'(DEPTH));
  assign out_valid = (level_q != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem_q[rd_q];

  // Storage is written only on an accepted push.
  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wr_q] <= in_data;
  end

  // Pointers wrap at DEPTH so that depth need not be a power of two.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
      level_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      if (pop)
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      if (push && !pop)
        level_q <= level_q + 1'b1;
      else if (pop && !push)
        level_q <= level_q - 1'b1;
    end
  end

  no_overfill_a : assert property (@(posedge clk) disable iff (rst)
    level_q <= (AW+1)'(DEPTH))
    else $error("fifo level above depth");
endmodule

// file: uemr_host_model.sv
// Host model: issues tokens and data packets to the responder.
// Assumes the responder samples on the rising edge of clk.
`timescale 1ns/1ps
module uemr_host_model
(
  // Clock
  input wire logic clk,
  // Token lines
  output logic tok_valid,
  output uemr_pkg::uemr_pid_t tok_pid,
  output logic tok_ep_valid,
  // Data packet lines
  output logic dat_start,
  output logic dat_byte_valid,
  output logic [7:0] dat_byte,
  input wire logic dat_byte_ready,
  output logic dat_end,
  output logic dat_crc_ok,
  output logic dat_err,
  output logic dat_toggle,
  output logic host_ack
);
  import uemr_pkg::*;

  // Idle levels; bus errors are not exercised by this model.
  initial
  begin
    {tok_valid, tok_ep_valid, dat_start, dat_byte_valid} = 4'h0;
    {dat_end, dat_crc_ok, dat_err, dat_toggle, host_ack} = 5'h00;
    tok_pid = pid_in;
    dat_byte = 8'h00;
  end

  // Tasks start and end just after a rising edge.
  task automatic token(input uemr_pid_t pid);
    tok_valid = 1'b1;
    tok_pid = pid;
    tok_ep_valid = 1'b1;
    @(posedge clk) #1;
    tok_valid = 1'b0;
  endtask

  task automatic dstart();
    dat_start = 1'b1;
    @(posedge clk) #1;
    dat_start = 1'b0;
  endtask

  // A byte is held until taken; the lines are inverted after release
  // so that a stale byte or status never passes for a fresh one.
  task automatic dbody(input int n, input logic ok, input logic tg);
    for (int i = 0; i < n; i++)
    begin
      dat_byte_valid = 1'b1;
      dat_byte = 8'hA0 + 8'(i);
      while (dat_byte_ready !== 1'b1) @(posedge clk) #1;
      @(posedge clk) #1;
    end
    dat_byte_valid = 1'b0;
    dat_byte = ~dat_byte;
    dat_end = 1'b1;
    {dat_crc_ok, dat_toggle} = {ok, tg};
    @(posedge clk) #1;
    dat_end = 1'b0;
    {dat_crc_ok, dat_toggle} = {~ok, ~tg};
  endtask

  // One-cycle host handshake after the responder's IN data.
  task automatic ack_pulse();
    host_ack = 1'b1;
    @(posedge clk) #1;
    host_ack = 1'b0;
  endtask
endmodule

// file: uemr_pkg.sv
// Types shared by the endpoint mode responder files.
// Assumes nothing beyond a SystemVerilog compiler.
package uemr_pkg;

  // Token kind delivered by the packet decoder.
  typedef enum logic [1:0] {pid_setup, pid_in, pid_out} uemr_pid_t;

  // Handshake or data answer sent back to the host.
  typedef enum logic [2:0]
  {
    resp_ack,
    resp_nak,
    resp_stall,
    resp_tx0,
    resp_txcnt
  } uemr_resp_t;

  // Action chosen for a token from the endpoint mode.
  typedef enum logic [3:0]
  {
    act_ignore,
    act_setup,
    act_ack,
    act_nak,
    act_stall,
    act_check,
    act_iso,
    act_tx0,
    act_txcnt
  } uemr_act_t;

  // Transaction sequencer states.
  typedef enum logic [1:0] {st_idle, st_data, st_txwait} uemr_state_t;

endpackage

// file: uemr_responder.sv
// Endpoint mode responder of a full-speed serial_interface_engine: answers
// SETUP, IN and OUT tokens from the mode bits, keeps status and count
// registers, and locks them against firmware writes after an ACK.
// Assumes a packet decoder on the same clock delivers tokens and data.
//
// Function
// [RULE1] Answer valid transactions only, ignore others.
// [RULE2] Interrupt on completion or buffer corruption.
// [RULE3] Corruption: OUT/SETUP ending with bad CRC.
// [RULE4] Valid data: count below size plus 2.
// [RULE5] OUT endpoints ignore IN, IN ignore OUT.
// [RULE6] IN/OUT status set at transaction end.
// [RULE7] SETUP status set at data phase start.
// [RULE8] ACKed transaction locks mode and count writes.
// [RULE9] Only a register read releases the lock.
// [RULE10] SETUP bit stays writable while locked.
// [RULE11] Lockout lasts about one microsecond.
// [RULE12] Firmware checks SETUP bit before mode write.
// [RULE13] Firmware reads mode at interrupt start.
// [RULE14] Low nibble of mode register selects response.
// [RULE15] Reset to disabled; disabled stays until firmware.
// [RULE16] Accepted SETUP switches mode to NAK in/out.
// [RULE17] ACK modes fall to NAK modes, 1010/1110 excepted.
// [RULE18] Disabled mode ignores everything, no interrupt.
// [RULE19] NAK/stall modes answer, set status, interrupt.
// [RULE20] Valid SETUP stored, ACKed; bad one only interrupts.
`timescale 1ns/1ps
`include "uemr_consts.svh"
module uemr_responder #(
  parameter int EP_SIZE = 8,
  parameter int FIFO_DEPTH = 4
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Token from the packet decoder
  input wire logic tok_valid,
  input wire uemr_pkg::uemr_pid_t tok_pid,
  input wire logic tok_ep_valid,
  // Data packet from the packet decoder, payload bytes without CRC
  input wire logic dat_start,
  input wire logic dat_byte_valid,
  input wire logic [7:0] dat_byte,
  output logic dat_byte_ready,
  input wire logic dat_end,
  input wire logic dat_crc_ok,
  input wire logic dat_err,
  input wire logic dat_toggle,
  // Host handshake after our IN data
  input wire logic host_ack,
  // Answer to the host
  output logic resp_valid,
  output uemr_pkg::uemr_resp_t resp_code,
  // Firmware register ports
  input wire logic mode_wr,
  input wire logic [7:0] mode_wdata,
  input wire logic mode_rd,
  output logic [7:0] mode_rdata,
  input wire logic cnt_wr,
  input wire logic [7:0] cnt_wdata,
  input wire logic cnt_rd,
  output logic [7:0] cnt_rdata,
  input wire logic stall_en,
  output logic wr_locked,
  output logic ep_irq,
  // Receive buffer drain
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [7:0] rx_data
);
  import uemr_pkg::*;

  localparam int LOCK_CYC = (`UEMR_LOCK_TIME_NS * `UEMR_CLK_MHZ) / 1000;

  uemr_state_t state_q, state_d;
  uemr_act_t act_q, act_d;
  logic [3:0] mode_q;
  logic setup_bit_q, in_bit_q, out_bit_q, ack_bit_q;
  logic [3:0] cnt_q;
  logic dval_q, data_toggle_bit_q;
  logic [4:0] byte_cnt_q;
  logic lock_q;
  logic [5:0] hold_q;
  logic resp_valid_q, ep_irq_q;
  uemr_resp_t resp_code_q;
  // Events from the sequencer to the register processes.
  logic hw_mode, set_setup, set_in, set_out, set_ack, upd_data, do_lock;
  logic do_irq, resp_fire, pkt_good, storing, fifo_in_ready;
  logic [3:0] hw_mode_val;
  uemr_resp_t resp_val;

  // Response to an OUT token per mode; IN-only modes ignore OUT.
  function automatic uemr_act_t out_act(logic [3:0] m, logic st);
    unique case (m)
      `UEMR_MODE_NAK_IO, `UEMR_MODE_NAK_OUT,
      `UEMR_MODE_NAK_OUT_SIN: out_act = act_nak;
      `UEMR_MODE_STALL_IO, `UEMR_MODE_STATUS_IN: out_act = act_stall;
      `UEMR_MODE_STATUS_OUT, `UEMR_MODE_NAK_IN_SOUT,
      `UEMR_MODE_ACK_IN_SOUT: out_act = act_check;
      `UEMR_MODE_ISO_OUT: out_act = act_iso;
      `UEMR_MODE_ACK_OUT: out_act = st ? act_stall : act_ack;
      `UEMR_MODE_ACK_OUT_SIN: out_act = act_ack;
      default: out_act = act_ignore;
    endcase
  endfunction

  // Response to an IN token per mode; OUT-only modes ignore IN.
  function automatic uemr_act_t in_act(logic [3:0] m, logic st);
    unique case (m)
      `UEMR_MODE_NAK_IO, `UEMR_MODE_NAK_IN,
      `UEMR_MODE_NAK_IN_SOUT: in_act = act_nak;
      `UEMR_MODE_STALL_IO, `UEMR_MODE_STATUS_OUT: in_act = act_stall;
      `UEMR_MODE_STATUS_IN, `UEMR_MODE_NAK_OUT_SIN,
      `UEMR_MODE_ACK_OUT_SIN: in_act = act_tx0;
      `UEMR_MODE_ISO_IN: in_act = act_iso;
      `UEMR_MODE_ACK_IN: in_act = st ? act_stall : act_txcnt;
      `UEMR_MODE_ACK_IN_SOUT: in_act = act_txcnt;
      default: in_act = act_ignore;
    endcase
  endfunction

  // Modes that take a SETUP; disabled and non-control modes do not.
  function automatic logic takes_setup(logic [3:0] m);
    unique case (m)
      `UEMR_MODE_NAK_IO, `UEMR_MODE_STATUS_OUT, `UEMR_MODE_STALL_IO,
      `UEMR_MODE_IGNORE_IO, `UEMR_MODE_STATUS_IN, `UEMR_MODE_NAK_OUT_SIN,
      `UEMR_MODE_ACK_OUT_SIN, `UEMR_MODE_NAK_IN_SOUT,
      `UEMR_MODE_ACK_IN_SOUT: takes_setup = 1'b1;
      default: takes_setup = 1'b0;
    endcase
  endfunction

  // Packet validity: size including CRC and every error check.
  assign pkt_good = dat_crc_ok && !dat_err &&
    (int'(byte_cnt_q) + `UEMR_CRC_BYTES < EP_SIZE + `UEMR_CRC_BYTES); // RULE4
  assign storing = (state_q == st_data) &&
    (act_q == act_setup || act_q == act_ack || act_q == act_iso);

  // Sequencer: decides answers and the register events of each cycle.
  always_comb
  begin
    state_d = state_q;
    act_d = act_q;
    hw_mode = 1'b0;
    hw_mode_val = mode_q;
    set_setup = 1'b0;
    set_in = 1'b0;
    set_out = 1'b0;
    set_ack = 1'b0;
    upd_data = 1'b0;
    do_lock = 1'b0;
    do_irq = 1'b0;
    resp_fire = 1'b0;
    resp_val = resp_ack;
    unique case (state_q)
      st_idle:
      begin
        // Tokens for other endpoints are never answered.
        if (tok_valid && tok_ep_valid) // RULE1
        begin
          unique case (tok_pid)
            pid_setup:
            begin
              if (takes_setup(mode_q)) // RULE18
              begin
                state_d = st_data;
                act_d = act_setup;
              end
            end
            pid_out:
            begin
              act_d = out_act(mode_q, stall_en); // RULE5
              if (act_d != act_ignore)
                state_d = st_data;
            end
            pid_in:
            begin
              act_d = in_act(mode_q, stall_en); // RULE5
              unique case (act_d)
                act_nak, act_stall:
                begin
                  resp_fire = 1'b1; // RULE19
                  resp_val = (act_d == act_nak) ? resp_nak : resp_stall;
                  set_in = 1'b1;
                  do_irq = 1'b1;
                end
                act_iso:
                begin
                  resp_fire = 1'b1;
                  resp_val = resp_txcnt;
                  set_in = 1'b1;
                  do_irq = 1'b1;
                end
                act_tx0, act_txcnt:
                begin
                  resp_fire = 1'b1;
                  resp_val = (act_d == act_tx0) ? resp_tx0 : resp_txcnt;
                  state_d = st_txwait;
                end
                default:
                begin
                end
              endcase
            end
            default:
            begin
            end
          endcase
        end
      end
      st_data:
      begin
        if (dat_start && act_q == act_setup)
          set_setup = 1'b1; // RULE7
        if (dat_end)
        begin
          state_d = st_idle;
          do_irq = !dat_crc_ok; // RULE3
          unique case (act_q)
            act_setup, act_ack, act_iso:
            begin
              upd_data = 1'b1; // RULE20
              set_out = (act_q != act_setup); // RULE6
              do_irq = 1'b1; // RULE2
              if (pkt_good && act_q != act_iso)
              begin
                resp_fire = 1'b1;
                set_ack = 1'b1;
                do_lock = 1'b1;
                hw_mode = 1'b1;
                if (act_q == act_setup)
                  hw_mode_val = `UEMR_MODE_NAK_IO; // RULE16
                else
                  hw_mode_val = {mode_q[3:1], 1'b0}; // RULE17
              end
            end
            act_check:
            begin
              if (pkt_good)
              begin
                resp_fire = 1'b1;
                set_out = 1'b1;
                do_irq = 1'b1;
                if (byte_cnt_q == '0 && dat_toggle)
                begin
                  set_ack = 1'b1;
                  do_lock = 1'b1;
                end
                else
                  resp_val = resp_stall;
              end
            end
            default:
            begin
              if (pkt_good)
              begin
                resp_fire = 1'b1; // RULE19
                resp_val = (act_q == act_nak) ? resp_nak : resp_stall;
                set_out = 1'b1;
                do_irq = 1'b1;
              end
            end
          endcase
        end
      end
      st_txwait:
      begin
        // A new token means the host never acknowledged our data.
        if (host_ack)
        begin
          state_d = st_idle;
          set_in = 1'b1; // RULE6
          set_ack = 1'b1;
          do_lock = 1'b1;
          do_irq = 1'b1;
          if (mode_q == `UEMR_MODE_ACK_IN || mode_q == `UEMR_MODE_ACK_IN_SOUT)
          begin
            hw_mode = 1'b1;
            hw_mode_val = {mode_q[3:1], 1'b0}; // RULE17
          end
        end
        else if (tok_valid)
          state_d = st_idle;
      end
      default:
        state_d = st_idle;
    endcase
  end

  // Sequencer state and the answer to the host.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= st_idle;
      act_q <= act_ignore;
      resp_valid_q <= 1'b0;
      resp_code_q <= resp_ack;
      ep_irq_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      act_q <= act_d;
      resp_valid_q <= resp_fire;
      resp_code_q <= resp_fire ? resp_val : resp_code_q;
      ep_irq_q <= do_irq; // RULE2
    end
  end

  // Payload byte counter, saturating so long packets stay oversize.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      byte_cnt_q <= '0;
    else if (state_q != st_data)
      byte_cnt_q <= '0;
    else if (dat_byte_valid && dat_byte_ready && byte_cnt_q != 5'h1F)
      byte_cnt_q <= byte_cnt_q + 5'h01;
  end

  // Mode field: hardware changes beat firmware, which the lock gates.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      mode_q <= 4'(`UEMR_MODE_RESET); // RULE15
    else if (hw_mode)
      mode_q <= hw_mode_val;
    else if (mode_wr && !lock_q) // RULE8
      mode_q <= mode_wdata[3:0]; // RULE14
  end

  // Token status bits; a hardware set wins over a firmware write.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      setup_bit_q <= 1'b0;
      in_bit_q <= 1'b0;
      out_bit_q <= 1'b0;
      ack_bit_q <= 1'b0;
    end
    else
    begin
      if (set_setup)
        setup_bit_q <= 1'b1;
      else if (mode_wr) // RULE10
        setup_bit_q <= mode_wdata[`UEMR_MODE_SETUP_BIT];
      if (set_in)
        in_bit_q <= 1'b1;
      else if (mode_wr && !lock_q)
        in_bit_q <= mode_wdata[`UEMR_MODE_IN_BIT];
      if (set_out)
        out_bit_q <= 1'b1;
      else if (mode_wr && !lock_q)
        out_bit_q <= mode_wdata[`UEMR_MODE_OUT_BIT];
      if (set_ack)
        ack_bit_q <= 1'b1;
      else if (mode_wr && !lock_q)
        ack_bit_q <= mode_wdata[`UEMR_MODE_ACK_BIT];
    end
  end

  // Count register: byte count, data-valid flag and data toggle.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 4'(`UEMR_CNT_RESET);
      dval_q <= 1'b0;
      data_toggle_bit_q <= 1'b0;
    end
    else if (upd_data)
    begin
      cnt_q <= (byte_cnt_q > 5'h0F) ? 4'hF : byte_cnt_q[3:0];
      dval_q <= pkt_good;
      data_toggle_bit_q <= dat_toggle;
    end
    else if (cnt_wr && !lock_q) // RULE8
    begin
      cnt_q <= cnt_wdata[3:0];
      dval_q <= cnt_wdata[`UEMR_CNT_DVAL_BIT];
      data_toggle_bit_q <= cnt_wdata[`UEMR_CNT_TOG_BIT];
    end
  end

  // Write lock: held for the lockout time, then freed by a read.
  // Early reads are ignored so the engine finishes its own update.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      lock_q <= 1'b0;
      hold_q <= '0;
    end
    else if (do_lock)
    begin
      lock_q <= 1'b1; // RULE8
      hold_q <= 6'(LOCK_CYC); // RULE11
    end
    else
    begin
      if (hold_q != '0)
        hold_q <= hold_q - 6'h01;
      else if (mode_rd || cnt_rd)
        lock_q <= 1'b0; // RULE9
    end
  end

  // Stored packets go to the buffer; other data is simply accepted.
  // Bytes past the endpoint size are dropped, so a full buffer must not
  // stall them, or an oversize packet would never reach its end.
  assign dat_byte_ready = (storing && int'(byte_cnt_q) < EP_SIZE) ?
    fifo_in_ready : 1'b1;

  uemr_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(storing && dat_byte_valid &&
      int'(byte_cnt_q) < EP_SIZE),
    .in_ready(fifo_in_ready),
    .in_data(dat_byte),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  assign mode_rdata = {setup_bit_q, in_bit_q, out_bit_q, ack_bit_q, mode_q};
  assign cnt_rdata = {data_toggle_bit_q, dval_q, 2'b00, cnt_q};
  assign resp_valid = resp_valid_q;
  assign resp_code = resp_code_q;
  assign ep_irq = ep_irq_q;
  assign wr_locked = lock_q;

  disabled_ignore_a : assert property (@(posedge clk) disable iff (rst)
    tok_valid && mode_q == `UEMR_MODE_DISABLE |=> !resp_valid && !ep_irq
    && state_q == st_idle) // RULE18
    else $error("disabled endpoint answered");
  ack_locks_a : assert property (@(posedge clk) disable iff (rst)
    resp_fire && resp_val == resp_ack |=> lock_q) // RULE8
    else $error("ack did not lock registers");
  locked_mode_a : assert property (@(posedge clk) disable iff (rst)
    lock_q && !hw_mode |=> $stable(mode_q)) // RULE8
    else $error("locked mode changed");
  lock_hold_a : assert property (@(posedge clk) disable iff (rst)
    do_lock |=> lock_q [*8]) // RULE11
    else $error("lock released too early");
  unlock_read_a : assert property (@(posedge clk) disable iff (rst)
    lock_q && !mode_rd && !cnt_rd |=> lock_q) // RULE9
    else $error("lock released without read");
  setup_exempt_a : assert property (@(posedge clk) disable iff (rst)
    lock_q && mode_wr && !set_setup |=>
    setup_bit_q == $past(mode_wdata[`UEMR_MODE_SETUP_BIT])) // RULE10
    else $error("setup bit not writable");
  setup_nak_a : assert property (@(posedge clk) disable iff (rst)
    state_q == st_data && act_q == act_setup && dat_end && pkt_good
    |=> mode_q == `UEMR_MODE_NAK_IO && resp_code == resp_ack) // RULE16
    else $error("setup did not switch to nak mode");
  setup_early_a : assert property (@(posedge clk) disable iff (rst)
    state_q == st_data && act_q == act_setup && dat_start
    |=> setup_bit_q) // RULE7
    else $error("setup status late");
  oversize_a : assert property (@(posedge clk) disable iff (rst)
    state_q == st_data && dat_end && int'(byte_cnt_q) >= EP_SIZE
    |=> !resp_valid) // RULE4
    else $error("oversize packet answered");
  corrupt_irq_a : assert property (@(posedge clk) disable iff (rst)
    state_q == st_data && dat_end && !dat_crc_ok |=> ep_irq) // RULE3
    else $error("corruption without interrupt");
endmodule

// file: usb_endpoint_mode_responder_tb_top.sv
// Self-checking bench for the endpoint mode responder.
// Assumes a 25 MHz clock and the host model on the token side.
`timescale 1ns/1ps
module usb_endpoint_mode_responder_tb_top;
  import uemr_pkg::*;
  logic clk, rst, mode_wr, mode_rd, cnt_wr, cnt_rd, stall_en, rx_ready;
  logic [7:0] mode_wdata, cnt_wdata, dat_byte, mode_rdata, cnt_rdata;
  logic [7:0] rx_data;
  logic tok_valid, tok_ep_valid, dat_start, dat_byte_valid, dat_end;
  logic dat_crc_ok, dat_err, dat_toggle, host_ack, dat_byte_ready;
  logic resp_valid, wr_locked, ep_irq, rx_valid, irq_seen, resp_seen;
  uemr_pid_t tok_pid;
  uemr_resp_t resp_code;
  int fails = 0;
  int compares = 0;

  uemr_responder u_dut (.clk, .rst, .tok_valid, .tok_pid, .tok_ep_valid,
    .dat_start, .dat_byte_valid, .dat_byte, .dat_byte_ready, .dat_end,
    .dat_crc_ok, .dat_err, .dat_toggle, .host_ack, .resp_valid,
    .resp_code, .mode_wr, .mode_wdata, .mode_rd, .mode_rdata, .cnt_wr,
    .cnt_wdata, .cnt_rd, .cnt_rdata, .stall_en, .wr_locked, .ep_irq,
    .rx_valid, .rx_ready, .rx_data);
  uemr_host_model host (.clk, .tok_valid, .tok_pid, .tok_ep_valid,
    .dat_start, .dat_byte_valid, .dat_byte, .dat_byte_ready, .dat_end,
    .dat_crc_ok, .dat_err, .dat_toggle, .host_ack);

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Pulses are caught sticky, so a pulse one cycle early or late still
  // counts while a missing or spurious one does not.
  always @(posedge clk)
  begin
    if (ep_irq === 1'b1) irq_seen <= 1'b1;
    if (resp_valid === 1'b1) resp_seen <= 1'b1;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic answer(input logic v, input uemr_resp_t c, input logic i);
    repeat (2) @(posedge clk);
    #1;
    check(8'(resp_seen), 8'(v));
    if (v)
      check(8'(resp_code), 8'(c));
    check(8'(irq_seen), 8'(i));
    {irq_seen, resp_seen} = 2'b00;
  endtask

  // Firmware write or read of the mode (c=0) or count (c=1) register.
  task automatic wr(input logic c, input logic [7:0] v);
    {cnt_wr, mode_wr, cnt_wdata, mode_wdata} = {c, ~c, v, v};
    @(posedge clk) #1;
    {cnt_wr, mode_wr} = 2'b00;
  endtask

  task automatic rd(input logic c);
    {cnt_rd, mode_rd} = {c, ~c};
    @(posedge clk) #1;
    {cnt_rd, mode_rd} = 2'b00;
  endtask

  task automatic t_disabled();
    check(mode_rdata, 8'h00);
    check(cnt_rdata, 8'h00);
    host.token(pid_in);
    answer(1'b0, resp_nak, 1'b0);
    wr(1'b0, 8'h09);
    host.token(pid_in);
    answer(1'b0, resp_nak, 1'b0);
  endtask

  task automatic t_nak_stall();
    wr(1'b0, 8'h01);
    host.token(pid_in);
    answer(1'b1, resp_nak, 1'b1);
    check(8'(mode_rdata[6]), 8'h01);
    wr(1'b0, 8'h03);
    host.token(pid_out);
    host.dstart();
    host.dbody(0, 1'b1, 1'b0);
    answer(1'b1, resp_stall, 1'b1);
    check(8'(mode_rdata[5]), 8'h01);
    check(8'(wr_locked), 8'h00);
  endtask

  // Four bytes fill the buffer while the drain side stalls.
  task automatic t_ack_out();
    wr(1'b0, 8'h0B);
    rx_ready = 1'b0;
    host.token(pid_out);
    host.dstart();
    host.dbody(4, 1'b1, 1'b1);
    answer(1'b1, resp_ack, 1'b1);
    check(mode_rdata, 8'h3A);
    check(cnt_rdata, 8'hC4);
    check(8'(wr_locked), 8'h01);
    wr(1'b0, 8'h01);
    wr(1'b1, 8'h00);
    check(mode_rdata, 8'h3A);
    check(cnt_rdata, 8'hC4);
    rd(1'b0);
    check(8'(wr_locked), 8'h01);
    repeat (25) @(posedge clk);
    #1;
    rd(1'b1);
    check(8'(wr_locked), 8'h00);
    rx_ready = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      check(8'(rx_valid), 8'h01);
      check(rx_data, 8'hA0 + 8'(i));
      @(posedge clk) #1;
    end
    check(8'(rx_valid), 8'h00);
  endtask

  task automatic t_bad();
    wr(1'b0, 8'h0B);
    host.token(pid_out);
    host.dstart();
    host.dbody(2, 1'b0, 1'b0);
    answer(1'b0, resp_ack, 1'b1);
    check(8'(mode_rdata[3:0]), 8'h0B);
    host.token(pid_out);
    host.dstart();
    host.dbody(8, 1'b1, 1'b0);
    answer(1'b0, resp_ack, 1'b1);
    check(8'(cnt_rdata[6]), 8'h00);
  endtask

  task automatic t_setup();
    wr(1'b0, 8'h02);
    host.token(pid_setup);
    host.dstart();
    check(8'(mode_rdata[7]), 8'h01);
    host.dbody(2, 1'b1, 1'b0);
    answer(1'b1, resp_ack, 1'b1);
    check(8'(mode_rdata[3:0]), 8'h01);
    check(8'(wr_locked), 8'h01);
    wr(1'b0, 8'h00);
    check(mode_rdata, 8'h11);
    rd(1'b0);
    check(8'(mode_rdata[7]), 8'h00);
  endtask

  // Data IN closed by the host's handshake, then a stalled IN.
  task automatic t_in();
    repeat (25) @(posedge clk);
    #1;
    rd(1'b0);
    wr(1'b0, 8'h0F);
    host.token(pid_in);
    answer(1'b1, resp_txcnt, 1'b0);
    check(8'(mode_rdata[6]), 8'h00);
    host.ack_pulse();
    answer(1'b0, resp_ack, 1'b1);
    check(mode_rdata, 8'h5E);
    check(8'(wr_locked), 8'h01);
    repeat (25) @(posedge clk);
    #1;
    rd(1'b0);
    check(8'(wr_locked), 8'h00);
    stall_en = 1'b1;
    wr(1'b0, 8'h0D);
    host.token(pid_in);
    answer(1'b1, resp_stall, 1'b1);
    stall_en = 1'b0;
  endtask

  task automatic print_verdict();
    if (fails == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Stall bit starts off; the bench raises it only for the stalled IN at the end of t_in.
  initial
  begin
    {rst, mode_wr, mode_rd, cnt_wr, cnt_rd, stall_en} = 6'h20;
    {rx_ready, irq_seen, resp_seen} = 3'b100;
    {mode_wdata, cnt_wdata} = 16'h0000;
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    t_disabled();
    t_nak_stall();
    t_ack_out();
    t_bad();
    t_setup();
    t_in();
    print_verdict();
  end

  // Watchdog well beyond the fewer than two hundred cycles the tests need.
  initial
  begin
    #200000;
    fails++;
    print_verdict();
  end
endmodule
